// *** src/cee_exception_unit.sv ***
// Exception entry and exit logic with its Wishbone register port.
// What this block does
// - Entry writes the banked link register with the PC plus a cause offset.
// - Wide traps save PC+4, compact PC+2; interrupts/fetch PC+4; load/store PC+8.
// - Entry copies the current status word into the target mode's saved word.
// - Entry overwrites the state code field with the exception's mode.
// - State codes: fast 10001, normal 10010, supervisor 10011, fault 10111, 11011.
// - Entry redirects fetch to the exception vector.
// - Vectors 0x00 to 0x1C by cause, 0x14 unused.
// - Entry clears the compact-state flag as the vector loads.
// - Entry sets the normal mask, and on fast entry also the fast mask, to prevent uncontrolled nesting.
// - Status restore returns the compact flag to its saved value.
// - Subtracting return restores PC from link minus the 4-bit return offset, and status.
// - Coinciding exceptions are serviced in fixed priority.
// - Order: reset, load/store, fast, normal, fetch, then trap or call.
// - Fast request is active low, sampled at instruction end when unmasked.
// - With sync select low requests pass a synchroniser delay first.
// - Fast mask blocks fast requests; user mode cannot change it.
// - Normal request ranks below fast and is masked on fast entry.
// - Normal mask blocks normal requests; only privileged modes change it.
// - Abort input sampled in memory cycles, classed as fetch or data fault.
// - Fetch fault tags instruction; raised only if it reaches the head.
// - Faulted single-word transfer still performs base write-back.
// - Faulted atomic swap leaves all state unchanged.
// - Faulted multi transfer completes, writes base, blocks later overwrites.
// - Software call enters supervisor; its return restores PC and status.
// - Unexecutable instruction takes the unknown-opcode trap.
// - Reset release: supervisor, both masks set, compact clear, fetch from zero.
//
// Our own choices: the Wishbone register port and the register offsets.
`default_nettype none
`timescale 1ns/100ps
module cee_exception_unit
  import cee_pkg::*;
(
  // Clock and reset.
  input  wire logic                    core_clk,
  input  wire logic                    reset,
  // Interrupt request pins.
  input  wire logic                    fast_request_low_in,
  input  wire logic                    normal_request_low_in,
  input  wire logic                    request_sync_select,
  // Memory abort and cycle type.
  input  wire logic                    abortIn,
  input  wire logic                    fetchCycle,
  input  wire logic                    dataCycle,
  input  wire logic [1:0]              xferKind,
  input  wire logic                    xferWriteBack,
  // Pipeline.
  input  wire logic                    instrEnd,
  input  wire logic [cee_pkg::CEE_XLEN-1:0] instrPc,
  input  wire logic                    unknownOpcode,
  input  wire logic                    softwareCall,
  input  wire logic                    pipeFlush,
  // Return request.
  input  wire logic                    retReq,
  input  wire logic [3:0]              retOffset,
  // Fetch redirect and status.
  output logic                         fetchRedirect_q,
  output logic [cee_pkg::CEE_XLEN-1:0] fetchAddr_q,
  output logic [cee_pkg::CEE_XLEN-1:0] statusWord_q,
  output logic                         exceptionTaken_q,
  output logic [2:0]                   lastCause_q,
  output logic                         busy_q,
  // Transfer side effects.
  output logic                         regWriteBlock_q,
  output logic                         baseWbAllow_q,
  // Wishbone slave.
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  input  wire logic                    wb_we_i,
  input  wire logic [cee_pkg::CEE_WB_AW-1:0] wb_adr_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic [cee_pkg::CEE_XLEN-1:0] wb_dat_i,
  output logic [cee_pkg::CEE_XLEN-1:0] wb_dat_o,
  output logic                         wb_ack_o
);
  import cee_pkg::*;

  cee_state_t        state_q, state_d;
  logic [31:0]       csw_d;
  logic              redirect_d, taken_d, busy_d, ack_d;
  logic [31:0]       fetchAddr_d, wbDat_d;
  logic [2:0]        cause_d;
  logic [1:0]        fetchTag_q, fetchTag_d;
  logic              dataFault_q, dataFault_d;
  logic              regBlock_d, baseWb_d;
  logic [3:0]        retOff_q, retOff_d;
  logic              fastReq, normalReq;
  logic [3:0]        bankSlot;
  logic [2:0]        memAddr;
  logic              memWe;
  logic [31:0]       linkWr, savedWr, linkRd, savedRd;
  logic              wbReq;
  logic [2:0]        pick;
  logic [31:0]       wrMask;

  cee_req_sync u_fast_sync (
    .core_clk   (core_clk),
    .reset      (reset),
    .reqLow     (fast_request_low_in),
    .syncSelect (request_sync_select),
    .req        (fastReq)
  );

  cee_req_sync u_normal_sync (
    .core_clk   (core_clk),
    .reset      (reset),
    .reqLow     (normal_request_low_in),
    .syncSelect (request_sync_select),
    .req        (normalReq)
  );

  cee_bank_mem #(.WIDTH(CEE_XLEN), .DEPTH(CEE_BANKS), .AW(CEE_BANK_W)) u_link_mem (
    .core_clk (core_clk),
    .addr     (memAddr),
    .wrEn     (memWe),
    .wrData   (linkWr),
    .rdData_q (linkRd)
  );

  cee_bank_mem #(.WIDTH(CEE_XLEN), .DEPTH(CEE_BANKS), .AW(CEE_BANK_W)) u_saved_mem (
    .core_clk (core_clk),
    .addr     (memAddr),
    .wrEn     (memWe),
    .wrData   (savedWr),
    .rdData_q (savedRd)
  );

  // Highest pending cause at the end of an instruction.
  always_comb begin
    pick = CEE_CAUSE_NONE;
    if (dataFault_q || (dataCycle && abortIn)) begin
      pick = CEE_CAUSE_LDST;
    end else if (fastReq && !statusWord_q[CEE_BIT_F]) begin
      pick = CEE_CAUSE_FIQ;
    end else if (normalReq && !statusWord_q[CEE_BIT_I]) begin
      pick = CEE_CAUSE_IRQ;
    end else if (fetchTag_q[1]) begin
      pick = CEE_CAUSE_FETCH;
    end else if (unknownOpcode) begin
      pick = CEE_CAUSE_UNDEF;
    end else if (softwareCall) begin
      pick = CEE_CAUSE_SWC;
    end
  end

  always_comb begin
    wbReq    = wb_cyc_i && wb_stb_i && !wb_ack_o;
    bankSlot = ceeBankOf(statusWord_q[4:0]);
    // Privileged modes may change masks and mode; user mode only the flags.
    wrMask   = ((statusWord_q[4:0] == CEE_MODE_USR) ? CEE_CSW_USER_MASK
                : CEE_CSW_PRIV_MASK) & ceeSelMask(wb_sel_i);
  end

  always_comb begin
    logic [4:0]  newMode;
    logic [31:0] vec;
    logic [31:0] off;
    logic [3:0]  slot;
    newMode     = CEE_MODE_SVC;
    vec         = CEE_VEC_RESET;
    off         = CEE_OFF_WIDE;
    slot        = bankSlot;
    state_d     = state_q;
    csw_d       = statusWord_q;
    redirect_d  = 1'b0;
    taken_d     = 1'b0;
    ack_d       = 1'b0;
    fetchAddr_d = fetchAddr_q;
    wbDat_d     = wb_dat_o;
    cause_d     = lastCause_q;
    retOff_d    = retOff_q;
    memWe       = 1'b0;
    linkWr      = instrPc;
    savedWr     = statusWord_q;
    case (state_q)
      CEE_ST_RSTENT: begin
        // Saved link value is left undefined by design; the PC is stored.
        slot        = ceeBankOf(CEE_MODE_SVC);
        memWe       = 1'b1;
        fetchAddr_d = CEE_VEC_RESET;
        redirect_d  = 1'b1;
        taken_d     = 1'b1;
        cause_d     = CEE_CAUSE_RESET;
        state_d     = CEE_ST_IDLE;
      end
      CEE_ST_IDLE: begin
        if (instrEnd && (pick != CEE_CAUSE_NONE)) begin
          case (pick)
            CEE_CAUSE_LDST: begin
              newMode = CEE_MODE_ABT;
              vec     = CEE_VEC_LDST;
              off     = CEE_OFF_LDST;
            end
            CEE_CAUSE_FIQ: begin
              newMode = CEE_MODE_FIQ;
              vec     = CEE_VEC_FIQ;
            end
            CEE_CAUSE_IRQ: begin
              newMode = CEE_MODE_IRQ;
              vec     = CEE_VEC_IRQ;
            end
            CEE_CAUSE_FETCH: begin
              newMode = CEE_MODE_ABT;
              vec     = CEE_VEC_FETCH;
            end
            CEE_CAUSE_UNDEF: begin
              newMode = CEE_MODE_UND;
              vec     = CEE_VEC_UNDEF;
              off     = statusWord_q[CEE_BIT_T] ? CEE_OFF_NARROW : CEE_OFF_WIDE;
            end
            default: begin
              newMode = CEE_MODE_SVC;
              vec     = CEE_VEC_SWC;
              off     = statusWord_q[CEE_BIT_T] ? CEE_OFF_NARROW : CEE_OFF_WIDE;
            end
          endcase
          slot               = ceeBankOf(newMode);
          memWe              = 1'b1;
          linkWr             = instrPc + off;
          savedWr            = statusWord_q;
          csw_d[4:0]         = newMode;
          csw_d[CEE_BIT_T]   = 1'b0;
          csw_d[CEE_BIT_I]   = 1'b1;
          if (pick == CEE_CAUSE_FIQ) begin
            csw_d[CEE_BIT_F] = 1'b1;
          end
          fetchAddr_d        = vec;
          redirect_d         = 1'b1;
          taken_d            = 1'b1;
          cause_d            = pick;
        end else if (retReq && (bankSlot != 4'h0)) begin
          retOff_d = retOffset;
          state_d  = CEE_ST_RET;
        end else if (wbReq) begin
          case (wb_adr_i)
            CEE_REG_CSW: begin
              ack_d   = 1'b1;
              wbDat_d = statusWord_q;
              if (wb_we_i) begin
                csw_d = (statusWord_q & ~wrMask) | (wb_dat_i & wrMask);
              end
            end
            CEE_REG_SAVED, CEE_REG_LINK: begin
              if (wb_we_i) begin
                ack_d   = 1'b1;
                memWe   = (bankSlot != 4'h0);
                linkWr  = (wb_adr_i == CEE_REG_LINK) ? wb_dat_i : linkRd;
                savedWr = (wb_adr_i == CEE_REG_SAVED) ? wb_dat_i : savedRd;
                state_d = CEE_ST_WBRD;
                ack_d   = 1'b0;
              end else begin
                state_d = CEE_ST_WBRD;
              end
            end
            CEE_REG_CAUSE: begin
              ack_d   = 1'b1;
              wbDat_d = {29'h0, lastCause_q};
            end
            default: begin
              ack_d   = 1'b1;
              wbDat_d = 32'h0;
            end
          endcase
        end
      end
      CEE_ST_RET: begin
        fetchAddr_d = linkRd - {28'h0, retOff_q};
        csw_d       = savedRd;
        redirect_d  = 1'b1;
        state_d     = CEE_ST_IDLE;
      end
      CEE_ST_WBRD: begin
        ack_d   = 1'b1;
        wbDat_d = (bankSlot == 4'h0) ? 32'h0
                  : ((wb_adr_i == CEE_REG_LINK) ? linkRd : savedRd);
        state_d = CEE_ST_IDLE;
      end
      default: begin
        state_d = CEE_ST_IDLE;
      end
    endcase
    memAddr = slot[2:0];
    busy_d  = (state_d != CEE_ST_IDLE);
  end

  // Fault tracking and transfer side effects.
  always_comb begin
    fetchTag_d  = fetchTag_q;
    dataFault_d = dataFault_q;
    regBlock_d  = regWriteBlock_q;
    if (fetchCycle) begin
      fetchTag_d = {fetchTag_q[0], abortIn};
    end
    if (pipeFlush || redirect_d) begin
      fetchTag_d = 2'b00;
    end
    if (taken_d && (cause_d == CEE_CAUSE_LDST)) begin
      dataFault_d = 1'b0;
    end
    if (instrEnd) begin
      regBlock_d = 1'b0;
    end
    if (dataCycle && abortIn) begin
      dataFault_d = !(instrEnd && state_q == CEE_ST_IDLE);
      if ((xferKind == CEE_XFER_MULTI) || (xferKind == CEE_XFER_SWAP)) begin
        regBlock_d = 1'b1;
      end
    end
    baseWb_d = xferWriteBack && ((xferKind == CEE_XFER_SINGLE) ||
                                 (xferKind == CEE_XFER_MULTI));
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state_q          <= CEE_ST_RSTENT;
      statusWord_q     <= CEE_CSW_RESET;
      fetchRedirect_q  <= 1'b0;
      fetchAddr_q      <= CEE_VEC_RESET;
      exceptionTaken_q <= 1'b0;
      lastCause_q      <= CEE_CAUSE_NONE;
      busy_q           <= 1'b1;
      retOff_q         <= 4'h0;
      fetchTag_q       <= 2'b00;
      dataFault_q      <= 1'b0;
      regWriteBlock_q  <= 1'b0;
      baseWbAllow_q    <= 1'b0;
      wb_dat_o         <= 32'h0;
      wb_ack_o         <= 1'b0;
    end else begin
      state_q          <= state_d;
      statusWord_q     <= csw_d;
      fetchRedirect_q  <= redirect_d;
      fetchAddr_q      <= fetchAddr_d;
      exceptionTaken_q <= taken_d;
      lastCause_q      <= cause_d;
      busy_q           <= busy_d;
      retOff_q         <= retOff_d;
      fetchTag_q       <= fetchTag_d;
      dataFault_q      <= dataFault_d;
      regWriteBlock_q  <= regBlock_d;
      baseWbAllow_q    <= baseWb_d;
      wb_dat_o         <= wbDat_d;
      wb_ack_o         <= ack_d;
    end
  end
endmodule // cee_exception_unit
`default_nettype wire

// *** src/cee_pkg.sv ***
// Shared constants, encodings and helper functions of the exception unit.
`default_nettype none
package cee_pkg;
  localparam int unsigned CEE_XLEN   = 32;
  localparam int unsigned CEE_WB_AW  = 4;
  localparam int unsigned CEE_BANKS  = 5;
  localparam int unsigned CEE_BANK_W = 3;

  // Processor state codes.
  localparam logic [4:0] CEE_MODE_USR = 5'h10;
  localparam logic [4:0] CEE_MODE_FIQ = 5'h11;
  localparam logic [4:0] CEE_MODE_IRQ = 5'h12;
  localparam logic [4:0] CEE_MODE_SVC = 5'h13;
  localparam logic [4:0] CEE_MODE_ABT = 5'h17;
  localparam logic [4:0] CEE_MODE_UND = 5'h1B;

  // Status word bit positions.
  localparam int unsigned CEE_BIT_T = 5;
  localparam int unsigned CEE_BIT_F = 6;
  localparam int unsigned CEE_BIT_I = 7;

  localparam logic [31:0] CEE_CSW_RESET     = 32'h000000D3;
  localparam logic [31:0] CEE_CSW_USER_MASK = 32'hF0000000;
  localparam logic [31:0] CEE_CSW_PRIV_MASK = 32'hF00000DF;

  // Vectors.
  localparam logic [31:0] CEE_VEC_RESET = 32'h00000000;
  localparam logic [31:0] CEE_VEC_UNDEF = 32'h00000004;
  localparam logic [31:0] CEE_VEC_SWC   = 32'h00000008;
  localparam logic [31:0] CEE_VEC_FETCH = 32'h0000000C;
  localparam logic [31:0] CEE_VEC_LDST  = 32'h00000010;
  localparam logic [31:0] CEE_VEC_IRQ   = 32'h00000018;
  localparam logic [31:0] CEE_VEC_FIQ   = 32'h0000001C;

  // Return address offsets.
  localparam logic [31:0] CEE_OFF_NARROW = 32'h00000002;
  localparam logic [31:0] CEE_OFF_WIDE   = 32'h00000004;
  localparam logic [31:0] CEE_OFF_LDST   = 32'h00000008;

  // Exception causes.
  localparam logic [2:0] CEE_CAUSE_NONE  = 3'h0;
  localparam logic [2:0] CEE_CAUSE_RESET = 3'h1;
  localparam logic [2:0] CEE_CAUSE_UNDEF = 3'h2;
  localparam logic [2:0] CEE_CAUSE_SWC   = 3'h3;
  localparam logic [2:0] CEE_CAUSE_FETCH = 3'h4;
  localparam logic [2:0] CEE_CAUSE_LDST  = 3'h5;
  localparam logic [2:0] CEE_CAUSE_IRQ   = 3'h6;
  localparam logic [2:0] CEE_CAUSE_FIQ   = 3'h7;

  // Transfer kinds.
  localparam logic [1:0] CEE_XFER_NONE   = 2'h0;
  localparam logic [1:0] CEE_XFER_SINGLE = 2'h1;
  localparam logic [1:0] CEE_XFER_SWAP   = 2'h2;
  localparam logic [1:0] CEE_XFER_MULTI  = 2'h3;

  // Register map.
  localparam logic [3:0] CEE_REG_CSW   = 4'h0;
  localparam logic [3:0] CEE_REG_SAVED = 4'h4;
  localparam logic [3:0] CEE_REG_LINK  = 4'h8;
  localparam logic [3:0] CEE_REG_CAUSE = 4'hC;

  typedef enum logic [3:0] {
    CEE_ST_RSTENT = 4'b0001,
    CEE_ST_IDLE   = 4'b0010,
    CEE_ST_RET    = 4'b0100,
    CEE_ST_WBRD   = 4'b1000
  } cee_state_t;

  // Bank slot of a mode; user and system modes have none.
  function automatic logic [3:0] ceeBankOf(input logic [4:0] mode);
    case (mode)
      CEE_MODE_FIQ: ceeBankOf = 4'h8;
      CEE_MODE_IRQ: ceeBankOf = 4'h9;
      CEE_MODE_SVC: ceeBankOf = 4'hA;
      CEE_MODE_ABT: ceeBankOf = 4'hB;
      CEE_MODE_UND: ceeBankOf = 4'hC;
      default:      ceeBankOf = 4'h0;
    endcase
  endfunction

  // Expands byte selects into a bit mask.
  function automatic logic [31:0] ceeSelMask(input logic [3:0] sel);
    ceeSelMask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction
endpackage
`default_nettype wire

// *** src/cee_bank_mem.sv ***
// Small banked word store with a registered read port.
`default_nettype none
`timescale 1ns/100ps
module cee_bank_mem #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 5,
  parameter int unsigned AW    = 3
) (
  // Clock.
  input  wire logic             core_clk,
  // Access port.
  input  wire logic [AW-1:0]    addr,
  input  wire logic             wrEn,
  input  wire logic [WIDTH-1:0] wrData,
  output logic      [WIDTH-1:0] rdData_q
);
  if (DEPTH > (1 << AW)) begin : g_bad_depth
    $error("cee_bank_mem: DEPTH does not fit AW");
  end

  logic [WIDTH-1:0] store [DEPTH];
  logic [WIDTH-1:0] rdData_d;

  always_comb begin
    rdData_d = (32'(addr) < DEPTH) ? store[addr] : '0;
  end

  always_ff @(posedge core_clk) begin
    if (wrEn && (32'(addr) < DEPTH)) begin
      store[addr] <= wrData;
    end
    rdData_q <= rdData_d;
  end
endmodule // cee_bank_mem
`default_nettype wire

// *** src/cee_req_sync.sv ***
// Request synchroniser that adds delay only for asynchronous requests.
`default_nettype none
`timescale 1ns/100ps
module cee_req_sync (
  // Clock and reset.
  input  wire logic core_clk,
  input  wire logic reset,
  // Request.
  input  wire logic reqLow,
  input  wire logic syncSelect,
  output logic      req
);
  logic stage1_q;
  logic stage2_q;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      stage1_q <= 1'b0;
      stage2_q <= 1'b0;
    end else begin
      stage1_q <= ~reqLow;
      stage2_q <= stage1_q;
    end
  end

  always_comb begin
    req = syncSelect ? ~reqLow : stage2_q;
  end
endmodule // cee_req_sync
`default_nettype wire

// *** testbench/cee_exception_unit_properties.sv ***
// Concurrent checks on the ports of the exception unit.
`timescale 1ns/100ps
`default_nettype none
module cee_exception_unit_properties (
  // Clock and reset.
  input wire logic        core_clk,
  input wire logic        reset,
  // Entry results.
  input wire logic [31:0] statusWord_q,
  input wire logic [31:0] fetchAddr_q,
  input wire logic        fetchRedirect_q,
  input wire logic        exceptionTaken_q,
  input wire logic [2:0]  lastCause_q,
  // Transfers and bus.
  input wire logic [1:0]  xferKind,
  input wire logic        xferWriteBack,
  input wire logic        baseWbAllow_q,
  input wire logic        dataCycle,
  input wire logic        abortIn,
  input wire logic        regWriteBlock_q,
  input wire logic        wb_ack_o
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  wire logic        tk = exceptionTaken_q;
  wire logic [2:0]  c  = lastCause_q;
  wire logic [31:0] s  = statusWord_q;
  property p_reset;
    $fell(reset) |=> tk && c == 3'h1 && fetchAddr_q == 32'h0 && s[7:0] == 8'hD3;
  endproperty
  a_reset: assert property (p_reset) else $error("reset entry wrong");
  property p_fast;
    tk && c == 3'h7 |-> fetchAddr_q == 32'h1C && s[4:0] == 5'h11 && s[7:6] == 2'h3;
  endproperty
  a_fast: assert property (p_fast) else $error("fast entry wrong");
  property p_normal;
    tk && c == 3'h6 |-> fetchAddr_q == 32'h18 && s[4:0] == 5'h12 && s[7];
  endproperty
  a_normal: assert property (p_normal) else $error("normal entry wrong");
  property p_fault;
    tk && (c == 3'h4 || c == 3'h5) |-> s[4:0] == 5'h17 &&
      fetchAddr_q == ((c == 3'h4) ? 32'hC : 32'h10);
  endproperty
  a_fault: assert property (p_fault) else $error("fault entry wrong");
  property p_trap;
    tk && (c == 3'h2 || c == 3'h3) |-> fetchAddr_q == ((c == 3'h2) ? 32'h4 : 32'h8) &&
      s[4:0] == ((c == 3'h2) ? 5'h1B : 5'h13);
  endproperty
  a_trap: assert property (p_trap) else $error("trap entry wrong");
  property p_wide;
    tk |-> !s[5] && fetchRedirect_q;
  endproperty
  a_wide: assert property (p_wide) else $error("entry kept compact state");
  property p_fmask;
    tk && c == 3'h7 |-> !$past(s[6]);
  endproperty
  a_fmask: assert property (p_fmask) else $error("masked fast taken");
  property p_imask;
    tk && c == 3'h6 |-> !$past(s[7]);
  endproperty
  a_imask: assert property (p_imask) else $error("masked normal taken");
  property p_wback;
    xferWriteBack && xferKind[0] |=> baseWbAllow_q;
  endproperty
  a_wback: assert property (p_wback) else $error("base write-back lost");
  property p_swap;
    xferKind == 2'h2 |=> !baseWbAllow_q;
  endproperty
  a_swap: assert property (p_swap) else $error("swap wrote back");
  property p_block;
    dataCycle && abortIn && xferKind[1] |=> regWriteBlock_q;
  endproperty
  a_block: assert property (p_block) else $error("overwrite not blocked");
  property p_ack;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack longer than one cycle");
  c_fast: cover property (tk && c == 3'h7);
  c_ldst: cover property (tk && c == 3'h5);
  c_block: cover property (regWriteBlock_q);
endmodule // cee_exception_unit_properties
bind cee_exception_unit cee_exception_unit_properties u_cee_exception_unit_properties (
  .core_clk(core_clk), .reset(reset), .statusWord_q(statusWord_q),
  .fetchAddr_q(fetchAddr_q), .fetchRedirect_q(fetchRedirect_q),
  .exceptionTaken_q(exceptionTaken_q), .lastCause_q(lastCause_q), .xferKind(xferKind),
  .xferWriteBack(xferWriteBack), .baseWbAllow_q(baseWbAllow_q), .dataCycle(dataCycle),
  .abortIn(abortIn), .regWriteBlock_q(regWriteBlock_q), .wb_ack_o(wb_ack_o));
`default_nettype wire

// *** testbench/cee_far_side.sv ***
// Interrupt source and memory abort model facing the exception unit.
`timescale 1ns/100ps
`default_nettype none
module cee_far_side (
  // Commands from the bench.
  input  wire logic wantFast,
  input  wire logic wantNormal,
  input  wire logic wantAbort,
  input  wire logic memCycle,
  // Pins.
  output logic      fastLow,
  output logic      normalLow,
  output logic      abortOut
);
  assign fastLow   = !wantFast;
  assign normalLow = !wantNormal;
  // The abort is only shown while a memory cycle is running.
  assign abortOut  = wantAbort && memCycle;
endmodule // cee_far_side
`default_nettype wire

// *** testbench/cee_exception_unit_test.sv ***
// Self-checking bench of the exception unit against a reference model.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((e) !== (g)) begin n_fail++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module cee_exception_unit_test;
  import cee_pkg::*;
  logic        core_clk = 1'h0, reset = 1'h1, syncSel = 1'h1;
  logic        wFast = 1'h0, wNorm = 1'h0, wAbort = 1'h0, fetchCycle = 1'h0;
  logic        dataCycle = 1'h0, xferWb = 1'h0, instrEnd = 1'h0, und = 1'h0;
  logic        swc = 1'h0, flush = 1'h0, retReq = 1'h0, cyc = 1'h0, we = 1'h0;
  logic [1:0]  xferKind = 2'h0;
  logic [3:0]  retOffset = 4'h0, wbAdr = 4'h0;
  logic [31:0] instrPc = 32'h0, wbDo = 32'h0, expSt, savedM, linkM, d;
  wire logic   fastLow, normLow, abortIn, redir, taken, busy, blk, bwb, ack;
  wire logic [2:0]  cause;
  wire logic [31:0] fetchAddr, status, wbDi;
  int          n_fail = 0, tests_run = 0;
  localparam logic [31:0] VEC [0:7] = '{32'h0, 32'h0, 32'h4, 32'h8, 32'hC, 32'h10,
                                        32'h18, 32'h1C};
  localparam logic [4:0] MODE [0:7] = '{5'h13, 5'h13, 5'h1B, 5'h13, 5'h17, 5'h17,
                                        5'h12, 5'h11};
  cee_far_side u_cee_far_side (.wantFast(wFast), .wantNormal(wNorm), .wantAbort(wAbort),
    .memCycle(fetchCycle || dataCycle), .fastLow(fastLow), .normalLow(normLow),
    .abortOut(abortIn));
  cee_exception_unit u_cee_exception_unit (.core_clk(core_clk), .reset(reset),
    .fast_request_low_in(fastLow), .normal_request_low_in(normLow),
    .request_sync_select(syncSel), .abortIn(abortIn), .fetchCycle(fetchCycle),
    .dataCycle(dataCycle), .xferKind(xferKind), .xferWriteBack(xferWb),
    .instrEnd(instrEnd), .instrPc(instrPc), .unknownOpcode(und), .softwareCall(swc),
    .pipeFlush(flush), .retReq(retReq), .retOffset(retOffset), .fetchRedirect_q(redir),
    .fetchAddr_q(fetchAddr), .statusWord_q(status), .exceptionTaken_q(taken),
    .lastCause_q(cause), .busy_q(busy), .regWriteBlock_q(blk), .baseWbAllow_q(bwb),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(wbAdr), .wb_sel_i(4'hF),
    .wb_dat_i(wbDo), .wb_dat_o(wbDi), .wb_ack_o(ack));
  always #25 core_clk = ~core_clk;
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // One classic Wishbone cycle; the model tracks status word writes.
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] v,
                    output logic [31:0] r);
    logic [31:0] m;
    @(posedge core_clk);
    cyc <= 1'h1;
    we <= w;
    wbAdr <= a;
    wbDo <= v;
    do begin
      @(posedge core_clk);
    end while (ack !== 1'h1);
    r = wbDi;
    cyc <= 1'h0;
    m = (expSt[4:0] == 5'h10) ? 32'hF0000000 : 32'hF00000DF;
    if (w && a == 4'h0) expSt = (expSt & ~m) | (v & m);
  endtask
  task automatic take(input logic [2:0] c, input logic u, input logic s);
    logic [31:0] pc;
    pc = $urandom() & 32'hFFFFFFFC;
    @(posedge core_clk);
    instrEnd <= 1'h1;
    instrPc <= pc;
    und <= u;
    swc <= s;
    @(posedge core_clk);
    instrEnd <= 1'h0;
    und <= 1'h0;
    swc <= 1'h0;
    @(negedge core_clk);
    savedM = expSt;
    linkM = pc + ((c == 3'h5) ? 32'h8 : (c < 3'h4 && expSt[5]) ? 32'h2 : 32'h4);
    expSt = {expSt[31:8], 1'h1, c == 3'h7 || expSt[6], 1'h0, MODE[c]};
    `CHK("taken", 1'h1, taken)
    `CHK("cause", c, cause)
    `CHK("vector", VEC[c], fetchAddr)
    `CHK("status", expSt, status)
    wb(1'h0, 4'h8, 32'h0, d);
    `CHK("link", linkM, d)
    wb(1'h0, 4'h4, 32'h0, d);
    `CHK("saved", savedM, d)
  endtask
  task automatic noTake;
    @(posedge core_clk);
    instrEnd <= 1'h1;
    @(posedge core_clk);
    instrEnd <= 1'h0;
    @(negedge core_clk);
    `CHK("no_entry", 1'h0, taken)
    @(posedge core_clk);
  endtask
  task automatic ret(input logic [3:0] off);
    int k;
    @(posedge core_clk);
    retReq <= 1'h1;
    retOffset <= off;
    @(posedge core_clk);
    retReq <= 1'h0;
    k = 0;
    do begin
      @(negedge core_clk);
      k++;
    end while (busy !== 1'h0 && k < 20);
    `CHK("ret_pc", linkM - off, fetchAddr)
    `CHK("ret_status", savedM, status)
    expSt = savedM;
    @(posedge core_clk);
  endtask
  initial begin
    #300000;
    n_fail++;
    close_out();
  end
  initial begin
    d = $urandom(77);
    repeat (16) @(posedge core_clk);
    reset <= 1'h0;
    @(posedge core_clk);
    @(negedge core_clk);
    `CHK("rst_status", 32'h000000D3, status)
    `CHK("rst_vector", 32'h0, fetchAddr)
    `CHK("rst_cause", 3'h1, cause)
    expSt = 32'h000000D3;
    wb(1'h1, 4'h0, {4'($urandom()), 20'h0, 8'h13}, d);
    wb(1'h0, 4'h2, 32'h0, d);
    wb(1'h0, 4'h0, 32'h0, d);
    `CHK("csw", expSt, d)
    wFast <= 1'h1;
    wNorm <= 1'h1;
    take(3'h7, 1'h0, 1'h0);
    ret(4'h4);
    dataCycle <= 1'h1;
    wAbort <= 1'h1;
    xferKind <= 2'h3;
    xferWb <= 1'h1;
    @(posedge core_clk);
    xferKind <= 2'h2;
    @(posedge core_clk);
    dataCycle <= 1'h0;
    wAbort <= 1'h0;
    xferKind <= 2'h0;
    xferWb <= 1'h0;
    take(3'h5, 1'h1, 1'h0);
    ret(4'h8);
    wFast <= 1'h0;
    take(3'h6, 1'h0, 1'h0);
    ret(4'h4);
    wb(1'h1, 4'h0, 32'h00000093, d);
    noTake();
    wNorm <= 1'h0;
    wb(1'h1, 4'h0, 32'h00000013, d);
    take(3'h2, 1'h1, 1'h0);
    ret(4'h0);
    take(3'h3, 1'h0, 1'h1);
    ret(4'h0);
    syncSel <= 1'h0;
    wFast <= 1'h1;
    noTake();
    take(3'h7, 1'h0, 1'h0);
    wFast <= 1'h0;
    ret(4'h4);
    syncSel <= 1'h1;
    fetchCycle <= 1'h1;
    wAbort <= 1'h1;
    @(posedge core_clk);
    fetchCycle <= 1'h0;
    wAbort <= 1'h0;
    noTake();
    fetchCycle <= 1'h1;
    @(posedge core_clk);
    fetchCycle <= 1'h0;
    take(3'h4, 1'h0, 1'h0);
    ret(4'h4);
    fetchCycle <= 1'h1;
    wAbort <= 1'h1;
    @(posedge core_clk);
    wAbort <= 1'h0;
    @(posedge core_clk);
    fetchCycle <= 1'h0;
    flush <= 1'h1;
    @(posedge core_clk);
    flush <= 1'h0;
    noTake();
    take(3'h3, 1'h0, 1'h1);
    wb(1'h1, 4'h4, 32'h00000033, d);
    savedM = 32'h00000033;
    ret(4'h0);
    take(3'h2, 1'h1, 1'h0);
    ret(4'h0);
    take(3'h3, 1'h0, 1'h1);
    wb(1'h1, 4'h4, 32'h00000013, d);
    savedM = 32'h00000013;
    ret(4'h0);
    wb(1'h1, 4'h0, 32'h00000010, d);
    wb(1'h1, 4'h0, 32'hA00000D3, d);
    wb(1'h0, 4'h0, 32'h0, d);
    `CHK("user_csw", expSt, d)
    close_out();
  end
endmodule // cee_exception_unit_test
`default_nettype wire
